// ===== rtl/tpo_cfg.svh
`ifndef TPO_CFG_SVH
`define TPO_CFG_SVH

// Clock period of pclk, 20 MHz
`define TPO_CLK_NS      50
// Busy pulse width per counter step
`define TPO_BUSY_NS     250
// Longest time from freeze to valid latched data
`define TPO_LATCH_NS    600
// Busy cycles, least time rounded up
`define TPO_BUSY_CYC    ((`TPO_BUSY_NS + `TPO_CLK_NS - 1) / `TPO_CLK_NS)
// Freeze settle cycles, longest time rounded down
`define TPO_LATCH_CYC   (`TPO_LATCH_NS / `TPO_CLK_NS)

// Register byte offsets
`define TPO_OFS_CTRL    8'h00
`define TPO_OFS_STATUS  8'h04
`define TPO_OFS_IRQ_EN  8'h08
`define TPO_OFS_IRQ_CLR 8'h0C
`define TPO_OFS_POS     8'h10
`define TPO_OFS_LATCH   8'h14

// Control field positions
`define TPO_CTRL_SWRES  0
`define TPO_CTRL_RES_LO 1
`define TPO_CTRL_RES_HI 2

// Status and enable bit positions
`define TPO_EV_WRAP     0
`define TPO_EV_DIRCHG   1
`define TPO_EV_LATCHOK  2
`define TPO_EV_STEP     3

// Reset values
`define TPO_CTRL_RST    3'h0
`define TPO_IRQ_EN_RST  4'h0

`endif

// ===== rtl/tpo_pkg.sv
`default_nettype none

package tpo_pkg;

	// Resolution codes on the select pins or control field
	typedef enum logic [1:0] {
		TPO_RES_10 = 2'b00,
		TPO_RES_12 = 2'b01,
		TPO_RES_14 = 2'b10,
		TPO_RES_16 = 2'b11
	} tpo_res_e;

	// Whole state of the top module
	typedef struct packed {
		logic [15:0] cnt;         // Position counter
		logic [15:0] latch;       // Output latches
		logic        dir;         // Rotation sense
		logic        wrap_pend;   // Wrap seen, waits one cycle
		logic        wrap_out;    // Wrap pulse pin
		logic [15:0] pos_o;       // Bus drive value
		logic [15:0] pos_oe;      // Bus drive enables
		logic [4:0]  frz_cnt;     // Cycles since freeze
		logic        up_prev;     // Step-up history
		logic        dn_prev;     // Step-down history
		logic [2:0]  ctrl;        // Control register
		logic [3:0]  irq_en;      // Interrupt enables
		logic [3:0]  status;      // Sticky events
		logic        irq;         // Interrupt pin
		logic [31:0] prdata;      // APB read data
		logic        pready;      // APB ready
		logic        pslverr;     // APB error
	} tpo_state_s;

endpackage : tpo_pkg

`default_nettype wire

// ===== rtl/tpo_sync.sv
`default_nettype none

// Two-stage synchroniser for a group of pin levels
module tpo_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,    // Clock
	input  wire logic         presetn, // Async reset, low
	input  wire logic [W-1:0] d,       // Raw pin levels
	output logic      [W-1:0] q        // Synchronised levels
);

	// First stage feeds only the second
	typedef struct packed {
		logic [W-1:0] s1; // Metastable stage
		logic [W-1:0] s2; // Safe stage
	} tpo_sync_s;

	tpo_sync_s s_reg;  // Current state
	tpo_sync_s s_next; // Next state

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		s_next    = s_reg;
		s_next.s1 = d;
		s_next.s2 = s_reg.s1;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign q = s_reg.s2;

endmodule : tpo_sync

`default_nettype wire

// ===== rtl/tpo_busy.sv
`default_nettype none

// Busy pulse generator, retriggered by each step
module tpo_busy #(
	parameter int CYC = 5
) (
	input  wire logic pclk,    // Clock
	input  wire logic presetn, // Async reset, low
	input  wire logic start,   // Counter stepped this cycle
	output logic      busy     // Busy pin, from flip-flop
);

	// Timer and output flop
	typedef struct packed {
		logic [7:0] cnt;  // Remaining cycles
		logic       busy; // Busy level
	} tpo_busy_s;

	tpo_busy_s s_reg;  // Current state
	tpo_busy_s s_next; // Next state

	////////////////////////////////////////////////////////////////
	// Retrigger keeps busy high through bursts of steps
	always_comb
	begin
		s_next = s_reg;
		if (start)
			s_next.cnt = 8'(CYC);
		else if (s_reg.cnt != 8'h00)
			s_next.cnt = 8'(s_reg.cnt - 8'h01);
		s_next.busy = (s_next.cnt != 8'h00);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign busy = s_reg.busy;

endmodule : tpo_busy

`default_nettype wire

// ===== rtl/tpo_top.sv
// Overview of operation
// - Output enable high floats data lines
// - Byte select high puts MSB low
// - Freeze low stops latch updates
// - Direction input low makes lines inputs
// - Busy high while position changes
// - Rotation-sense output shows direction
// - Wrap pulse on all-ones/all-zeros crossing
// - Two selects choose 10/12/14/16 bits
// - Each step moves counter while bus is an output, no command
// - Every counter step pulses busy
// - Counter follows steps continuously while bus is an output
// - Position is natural binary per revolution
// - Sense latched, valid before wrap
// - Wrap and sense ignore freeze
// - Latched data valid within 600 ns

`include "tpo_cfg.svh"

`default_nettype none

module tpo_top (
	input  wire logic        pclk,              // APB clock, 20 MHz
	input  wire logic        presetn,           // Async reset, low
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB access phase
	input  wire logic        pwrite,            // APB write
	input  wire logic [7:0]  paddr,             // APB byte address
	input  wire logic [31:0] pwdata,            // APB write data
	output logic      [31:0] prdata,            // APB read data
	output logic             pready,            // APB ready
	output logic             pslverr,           // APB error
	input  wire logic        step_up,           // Loop step up pin
	input  wire logic        step_dn,           // Loop step down pin
	input  wire logic        out_enable_n,      // High floats bus
	input  wire logic        byte_select,       // High gives MSB low
	input  wire logic        latch_freeze_n,    // Low freezes latches
	input  wire logic        bus_direction,     // Low makes bus input
	input  wire logic [1:0]  resolution_select, // Resolution pins
	input  wire logic [15:0] position_bus_i,    // Bus pin levels
	output logic      [15:0] position_bus_o,    // Bus drive value
	output logic      [15:0] position_bus_oe,   // Bus drive enables
	output logic             busy,              // Busy pin
	output logic             direction,         // Rotation sense pin
	output logic             wrap_pulse_out,    // Wrap pulse pin
	output logic             irq                // Interrupt level
);

	////////////////////////////////////////////////////////////////
	// Declarations

	tpo_pkg::tpo_state_s s_reg;  // Current state
	tpo_pkg::tpo_state_s s_next; // Next state

	logic [23:0] pin_raw;   // Pins before synchroniser
	logic [23:0] pin_s;     // Pins after synchroniser
	logic        up_s;      // Step up level
	logic        dn_s;      // Step down level
	logic        oe_n_s;    // Output enable level
	logic        bsel_s;    // Byte select level
	logic        frz_n_s;   // Freeze level
	logic        bdir_s;    // Bus direction level
	logic [1:0]  res_s;     // Resolution pins
	logic [15:0] bus_in_s;  // Bus input word
	logic        step_inc;  // One count up
	logic        step_dec;  // One count down
	logic        stepped;   // Counter stepped by a loop step
	logic [1:0]  res_code;  // Resolution in use
	logic [15:0] mask;      // Valid-bit mask
	logic [15:0] cur;       // Masked counter
	logic [15:0] word;      // Masked latch value
	logic        ev_wrap;   // Wrap event
	logic        ev_dir;    // Sense reversal event
	logic        ev_latch;  // Latch settled event
	logic [3:0]  ev;        // All events
	logic        setup;     // APB setup phase
	logic        wr_acc;    // APB write takes effect
	logic        hit;       // Mapped address

	////////////////////////////////////////////////////////////////
	// Resolution decode, fixed mapping of codes to widths
	function automatic logic [15:0] res_mask(input logic [1:0] code);
		case (tpo_pkg::tpo_res_e'(code))
			tpo_pkg::TPO_RES_10: res_mask = 16'h03FF;
			tpo_pkg::TPO_RES_12: res_mask = 16'h0FFF;
			tpo_pkg::TPO_RES_14: res_mask = 16'h3FFF;
			tpo_pkg::TPO_RES_16: res_mask = 16'hFFFF;
			default:             res_mask = 16'hFFFF;
		endcase
	endfunction : res_mask

	// Address decode, used by the error path only
	function automatic logic addr_hit(input logic [7:0] a);
		case (a)
			`TPO_OFS_CTRL,
			`TPO_OFS_STATUS,
			`TPO_OFS_IRQ_EN,
			`TPO_OFS_IRQ_CLR,
			`TPO_OFS_POS,
			`TPO_OFS_LATCH: addr_hit = 1'b1;
			default:        addr_hit = 1'b0;
		endcase
	endfunction : addr_hit

	////////////////////////////////////////////////////////////////
	// Pin synchronisers; every pin is asynchronous to pclk

	assign pin_raw = {position_bus_i, resolution_select, bus_direction,
		latch_freeze_n, byte_select, out_enable_n, step_dn, step_up};

	tpo_sync #(
		.W (24)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pin_raw),
		.q       (pin_s)
	);

	assign up_s     = pin_s[0];
	assign dn_s     = pin_s[1];
	assign oe_n_s   = pin_s[2];
	assign bsel_s   = pin_s[3];
	assign frz_n_s  = pin_s[4];
	assign bdir_s   = pin_s[5];
	assign res_s    = pin_s[7:6];
	assign bus_in_s = pin_s[23:8];

	////////////////////////////////////////////////////////////////
	// Busy pulse per counter step

	tpo_busy #(
		.CYC (`TPO_BUSY_CYC)
	) u_busy (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (stepped),
		.busy    (busy)
	);

	////////////////////////////////////////////////////////////////
	// Next state of the whole block
	always_comb
	begin
		s_next = s_reg;

		// Software override of the select pins
		res_code = s_reg.ctrl[`TPO_CTRL_SWRES] ?
			s_reg.ctrl[`TPO_CTRL_RES_HI:`TPO_CTRL_RES_LO] : res_s;
		mask = res_mask(res_code);
		cur  = s_reg.cnt & mask;

		// Rising edges of the step levels; both at once cancel
		step_inc = up_s & ~s_reg.up_prev & ~(dn_s & ~s_reg.dn_prev);
		step_dec = dn_s & ~s_reg.dn_prev & ~(up_s & ~s_reg.up_prev);
		s_next.up_prev = up_s;
		s_next.dn_prev = dn_s;

		// Counter tracks steps only while bus is an output
		stepped = bdir_s & (step_inc | step_dec);
		ev_wrap = 1'b0;
		ev_dir  = 1'b0;
		if (!bdir_s)
		begin
			// Bus as input presets the counter
			s_next.cnt = bus_in_s & mask;
		end
		else if (step_inc)
		begin
			// Count up, wrapping at selected width
			s_next.cnt = 16'(cur + 16'h0001) & mask;
			ev_wrap    = (cur == mask);
			ev_dir     = ~s_reg.dir;
			s_next.dir = 1'b1;
		end
		else if (step_dec)
		begin
			// Count down, wrapping at selected width
			s_next.cnt = 16'(cur - 16'h0001) & mask;
			ev_wrap    = (cur == 16'h0000);
			ev_dir     = s_reg.dir;
			s_next.dir = 1'b0;
		end
		else
		begin
			// Truncate on a resolution change
			s_next.cnt = cur;
		end

		// Wrap pin follows sense by one cycle so sense leads it
		s_next.wrap_pend = ev_wrap;
		s_next.wrap_out  = s_reg.wrap_pend;

		// Output latches; freeze stops transfers only
		ev_latch = 1'b0;
		if (frz_n_s)
		begin
			s_next.latch   = cur;
			s_next.frz_cnt = 5'h00;
		end
		else if (s_reg.frz_cnt != 5'(`TPO_LATCH_CYC))
		begin
			// Flag settling after TPO_LATCH_CYC cycles, the quoted time
			s_next.frz_cnt = 5'(s_reg.frz_cnt + 5'h01);
			ev_latch = (s_next.frz_cnt == 5'(`TPO_LATCH_CYC));
		end

		// Bus drive; unused high lines read zero
		word = s_reg.latch & mask;
		s_next.pos_o[15:8] = word[15:8];
		s_next.pos_o[7:0]  = bsel_s ? word[15:8] : word[7:0];
		s_next.pos_oe = {16{~oe_n_s & bdir_s}};

		// Sticky events; a new event beats a clear
		ev = '0;
		ev[`TPO_EV_WRAP]    = ev_wrap;
		ev[`TPO_EV_DIRCHG]  = ev_dir;
		ev[`TPO_EV_LATCHOK] = ev_latch;
		ev[`TPO_EV_STEP]    = stepped;

		// APB slave, one wait-free access phase
		setup  = psel & ~penable;
		wr_acc = psel & penable & pwrite & s_reg.pready;
		hit    = addr_hit(paddr);

		if (wr_acc & (paddr == `TPO_OFS_IRQ_CLR))
			s_next.status = s_reg.status & ~pwdata[3:0];
		s_next.status = s_next.status | ev;

		// Register writes
		if (wr_acc & (paddr == `TPO_OFS_CTRL))
			s_next.ctrl = pwdata[2:0];
		if (wr_acc & (paddr == `TPO_OFS_IRQ_EN))
			s_next.irq_en = pwdata[3:0];

		// Ready and answer formed in setup, shown in access
		s_next.pready  = setup;
		s_next.pslverr = setup & ~hit;
		if (setup & ~pwrite)
		begin
			case (paddr)
				`TPO_OFS_CTRL:   s_next.prdata = {29'h0, s_reg.ctrl};
				`TPO_OFS_STATUS: s_next.prdata = {28'h0, s_reg.status};
				`TPO_OFS_IRQ_EN: s_next.prdata = {28'h0, s_reg.irq_en};
				`TPO_OFS_POS:    s_next.prdata = {13'h0, busy, s_reg.dir,
					res_code == 2'b11, cur};
				`TPO_OFS_LATCH:  s_next.prdata = {16'h0, word};
				default:         s_next.prdata = 32'h0000_0000;
			endcase
		end
		else
		begin
			s_next.prdata = 32'h0000_0000;
		end

		// Level interrupt from enabled sticky bits
		s_next.irq = |(s_next.status & s_next.irq_en);
	end

	////////////////////////////////////////////////////////////////
	// State register; no pin reaches reset values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg        <= '0;
			s_reg.dir    <= 1'b1;
			s_reg.ctrl   <= `TPO_CTRL_RST;
			s_reg.irq_en <= `TPO_IRQ_EN_RST;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops

	assign prdata          = s_reg.prdata;
	assign pready          = s_reg.pready;
	assign pslverr         = s_reg.pslverr;
	assign position_bus_o  = s_reg.pos_o;
	assign position_bus_oe = s_reg.pos_oe;
	assign direction       = s_reg.dir;
	assign wrap_pulse_out  = s_reg.wrap_out;
	assign irq             = s_reg.irq;

endmodule : tpo_top

`default_nettype wire

// ===== tb/tpo_chk_asserts.sv
`default_nettype none

// Watches the pins of the position port for timing and level slips
module tpo_chk (
	input wire logic        pclk,            // Clock
	input wire logic        presetn,         // Reset, low
	input wire logic        psel,            // APB select
	input wire logic        penable,         // APB access
	input wire logic        pready,          // APB ready
	input wire logic        pslverr,         // APB error
	input wire logic        step_up,         // Step up pin
	input wire logic        step_dn,         // Step down pin
	input wire logic        out_enable_n,    // Float request
	input wire logic        byte_select,     // Byte steering
	input wire logic        bus_direction,   // Bus direction
	input wire logic [15:0] position_bus_o,  // Bus value
	input wire logic [15:0] position_bus_oe, // Bus enables
	input wire logic        busy,            // Busy pin
	input wire logic        direction,       // Sense pin
	input wire logic        wrap_pulse_out   // Wrap pin
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////
	// Pin windows allow for the two-flop synchroniser plus a register
	chk_bus_float: assert property (out_enable_n [*5] |-> position_bus_oe == 16'h0000)
		else $error("bus driven while disabled");
	chk_bus_drive: assert property ((!out_enable_n && bus_direction) [*5]
		|-> position_bus_oe == 16'hFFFF)
		else $error("bus not driven");
	chk_bus_input: assert property ((!bus_direction) [*5] |-> position_bus_oe == 16'h0000)
		else $error("bus driven in input mode");
	chk_msb_low: assert property (byte_select [*6]
		|-> position_bus_o[7:0] == position_bus_o[15:8])
		else $error("upper byte not on low lines");
	chk_busy_step: assert property ($rose(step_up) && !step_dn && bus_direction
		|-> ##[1:8] busy)
		else $error("step without busy");
	chk_busy_ends: assert property ((!step_up && !step_dn) [*8] |-> ##2 !busy)
		else $error("busy stuck high");
	chk_dir_up: assert property ($rose(step_up) && !step_dn && bus_direction
		|-> ##[1:6] direction)
		else $error("sense not up");
	chk_dir_down: assert property ($rose(step_dn) && !step_up && bus_direction
		|-> ##[1:6] !direction)
		else $error("sense not down");
	chk_wrap_width: assert property (wrap_pulse_out |=> !wrap_pulse_out)
		else $error("wrap pulse too long");
	chk_wrap_busy: assert property (wrap_pulse_out |-> busy)
		else $error("wrap without a step");
	chk_dir_first: assert property (wrap_pulse_out |-> $stable(direction))
		else $error("sense moved with wrap");
	chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");

	// Main scenarios reached
	cover property (wrap_pulse_out);
	cover property ($rose(busy));
	cover property (pslverr);
endmodule : tpo_chk

bind tpo_top tpo_chk tpo_chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .step_up(step_up), .step_dn(step_dn),
	.out_enable_n(out_enable_n), .byte_select(byte_select),
	.bus_direction(bus_direction), .position_bus_o(position_bus_o),
	.position_bus_oe(position_bus_oe), .busy(busy), .direction(direction),
	.wrap_pulse_out(wrap_pulse_out)
);

`default_nettype wire

// ===== tb/tpo_host_bus.sv
`default_nettype none

// Host side of the shared position bus
module tpo_host_bus (
	input  wire logic        pclk,     // Clock
	input  wire logic [15:0] dev_o,    // Device value
	input  wire logic [15:0] dev_oe,   // Device enables
	input  wire logic        host_drv, // Host drives
	input  wire logic [15:0] host_val, // Host value
	output logic      [15:0] wire_lvl  // Line levels
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] float_reg = 16'hA5A5; // Undriven lines wander

	// Released lines toggle, so stale data never looks valid
	always_ff @(posedge pclk)
		float_reg <= ~float_reg;

	// Host drives only where the device lets go
	always_comb
		for (int i = 0; i < 16; i++)
			wire_lvl[i] = dev_oe[i] ? dev_o[i] : (host_drv ? host_val[i] : float_reg[i]);
endmodule : tpo_host_bus

`default_nettype wire

// ===== tb/tracking_position_output_port_tb.sv
`include "tpo_cfg.svh"

`default_nettype none

module tracking_position_output_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        step_up, step_dn, out_enable_n, byte_select, latch_freeze_n;
	logic        bus_direction, busy, direction, wrap_pulse_out, irq, host_drv;
	logic [1:0]  resolution_select;
	logic [15:0] bus_i, bus_o, bus_oe, host_val, rnd, lo10;
	logic [32:0] q_exp[$], q_msk[$], mon_e, mon_m;
	int          mismatches, checked, wraps, seed;

	tpo_top tpo_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .step_up(step_up), .step_dn(step_dn), .out_enable_n(out_enable_n),
		.byte_select(byte_select), .latch_freeze_n(latch_freeze_n),
		.bus_direction(bus_direction), .resolution_select(resolution_select),
		.position_bus_i(bus_i), .position_bus_o(bus_o), .position_bus_oe(bus_oe),
		.busy(busy), .direction(direction), .wrap_pulse_out(wrap_pulse_out), .irq(irq));
	tpo_host_bus tpo_host_bus_inst (.pclk(pclk), .dev_o(bus_o), .dev_oe(bus_oe),
		.host_drv(host_drv), .host_val(host_val), .wire_lvl(bus_i));

	////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task finish_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	// APB master: request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		q_exp.push_back(e);
		q_msk.push_back(m);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the watchdog ends a wait that never sees ready
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		{psel, penable} <= 2'b00;
		// One idle edge, so the next call never drives psel twice at once
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, 33'h100000000);
	endtask : wr

	// One loop step, spaced so the synchroniser sees both levels
	task automatic step(input logic up);
		if (up)
			step_up <= 1'b1;
		else
			step_dn <= 1'b1;
		repeat (3) @(posedge pclk);
		{step_up, step_dn} <= 2'b00;
		@(posedge pclk);
		chk("busy", {32'h0, busy}, 33'h1);
		repeat (8) @(posedge pclk);
	endtask : step

	////////////////////////////////////////////////////////////////
	// Clock, watchdog and output monitor
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	initial
	begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		finish_test();
	end

	// Oldest expectation meets each APB answer
	always @(posedge pclk)
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && q_exp.size() > 0)
		begin
			mon_e = q_exp.pop_front();
			mon_m = q_msk.pop_front();
			chk("apb", {pslverr, prdata} & mon_m, mon_e & mon_m);
		end

	always @(posedge pclk)
		if (wrap_pulse_out === 1'b1)
			wraps++;

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		seed = 61638;
		{presetn, psel, penable, pwrite, step_up, step_dn, byte_select, host_drv} = '0;
		{out_enable_n, latch_freeze_n, bus_direction} = 3'b111;
		{paddr, pwdata, host_val} = '0;
		resolution_select = tpo_pkg::TPO_RES_16;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`TPO_OFS_CTRL, 32'h0);
		rd(`TPO_OFS_IRQ_EN, 32'h0);
		rd(`TPO_OFS_STATUS, 32'h0);
		rd(`TPO_OFS_POS, 32'h30000);
		apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
		// Each resolution wraps both ways at its own width
		for (int r = 0; r < 4; r++)
		begin
			resolution_select <= r[1:0];
			repeat (4) @(posedge pclk);
			step(1'b0);
			chk("dir", {32'h0, direction}, 33'h0);
			rd(`TPO_OFS_POS, (32'h0000FFFF >> (6 - 2 * r)) | (r == 3 ? 32'h10000 : 32'h0));
			step(1'b1);
			rd(`TPO_OFS_POS, 32'h20000 | (r == 3 ? 32'h10000 : 32'h0));
		end
		chk("wraps", 33'(wraps), 33'h8);
		// Events, enable, clear
		rd(`TPO_OFS_STATUS, 32'hB);
		chk("irq", {32'h0, irq}, 33'h0);
		wr(`TPO_OFS_IRQ_EN, 32'h2);
		wr(`TPO_OFS_STATUS, 32'h0);
		repeat (3) @(posedge pclk);
		chk("irq", {32'h0, irq}, 33'h1);
		rd(`TPO_OFS_STATUS, 32'hB);
		wr(`TPO_OFS_IRQ_CLR, 32'h2);
		rd(`TPO_OFS_STATUS, 32'h9);
		chk("irq", {32'h0, irq}, 33'h0);
		wr(`TPO_OFS_IRQ_CLR, 32'hF);
		rd(`TPO_OFS_IRQ_CLR, 32'h0);
		// Preset from the bus, then byte reads and freeze
		rnd = 16'($random(seed)) & 16'h7FFF;
		bus_direction <= 1'b0;
		host_drv <= 1'b1;
		host_val <= rnd;
		repeat (8) @(posedge pclk);
		chk("bus_oe", {17'h0, bus_oe}, 33'h0);
		{bus_direction, host_drv, out_enable_n} <= 3'b100;
		repeat (8) @(posedge pclk);
		rd(`TPO_OFS_POS, {16'h1, rnd}, 32'h1FFFF);
		chk("bus_o", {17'h0, bus_o}, {17'h0, rnd});
		chk("bus_oe", {17'h0, bus_oe}, 33'hFFFF);
		byte_select <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("bus_o", {17'h0, bus_o}, {17'h0, rnd[15:8], rnd[15:8]});
		latch_freeze_n <= 1'b0;
		repeat (14) @(posedge pclk);
		repeat (3) step(1'b1);
		rd(`TPO_OFS_LATCH, {16'h0, rnd});
		rd(`TPO_OFS_POS, 32'h30000 | (rnd + 32'h3));
		rd(`TPO_OFS_STATUS, 32'hC, 32'hC);
		chk("bus_o", {17'h0, bus_o}, {17'h0, rnd[15:8], rnd[15:8]});
		latch_freeze_n <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(`TPO_OFS_LATCH, {16'h0, rnd} + 32'h3);
		// Software override picks 10 bits; upper lines must read zero
		lo10 = 16'(rnd + 16'h0003) & 16'h03FF;
		wr(`TPO_OFS_CTRL, 32'h1);
		rd(`TPO_OFS_CTRL, 32'h1);
		rd(`TPO_OFS_POS, 32'h20000 | {16'h0, lo10});
		repeat (4) @(posedge pclk);
		chk("bus_o", {17'h0, bus_o}, {17'h0, lo10[15:8], lo10[15:8]});
		out_enable_n <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("bus_oe", {17'h0, bus_oe}, 33'h0);
		finish_test();
	end
endmodule : tracking_position_output_port_tb

`default_nettype wire
